// >>> rtl/smsbp_pkg.sv
// Constants and helpers shared by the byte port and its clock generator
package smsbp_pkg;

	// Control byte field positions
	localparam int CB_IRQ_EN  = 7;
	localparam int CB_EN      = 6;
	localparam int CB_LSB     = 5;
	localparam int CB_MST     = 4;
	localparam int CB_CPOL    = 3;
	localparam int CB_CPHA    = 2;
	localparam int CB_RATE_HI = 1;
	localparam int CB_RATE_LO = 0;

	// Status byte field positions
	localparam int SB_FLAG = 7;
	localparam int SB_WRITE_COLLISION_FLAG = 6;
	localparam int SB_DBL  = 0;

	// Pin indices into the pin vectors
	localparam int PIN_MOSI = 0;
	localparam int PIN_MISO = 1;
	localparam int PIN_SCK  = 2;
	localparam int PIN_SS   = 3;
	localparam int PIN_NUM  = 4;

	// Values after reset
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic       BIT_RST  = 1'b0;

	// Byte framing counts
	localparam logic [3:0] CNT_ZERO  = 4'h0;
	localparam logic [3:0] CNT_LAST  = 4'h7;
	localparam logic [3:0] CNT_FULL  = 4'h8;
	localparam logic [6:0] HALF_ONE  = 7'h01;

	// Master sequencer states
	typedef enum logic [1:0] {
		MS_IDLE = 2'b01,
		MS_RUN  = 2'b10
	} smsbp_mst_e;

	// Half SCK period in clk cycles for {double, rate_hi, rate_lo}
	function automatic logic [6:0] smsbp_half(input logic [2:0] sel);
		case (sel)
			3'h0:    smsbp_half = 7'h02;
			3'h1:    smsbp_half = 7'h08;
			3'h2:    smsbp_half = 7'h20;
			3'h3:    smsbp_half = 7'h40;
			3'h4:    smsbp_half = 7'h01;
			3'h5:    smsbp_half = 7'h04;
			3'h6:    smsbp_half = 7'h10;
			default: smsbp_half = 7'h20;
		endcase
	endfunction

	// One shift step in the chosen bit order
	function automatic logic [7:0] smsbp_shin(input logic [7:0] sh, input logic b, input logic lsb_first);
		smsbp_shin = lsb_first ? {b, sh[7:1]} : {sh[6:0], b};
	endfunction

endpackage

// >>> rtl/smsbp_clk_if.sv
// Link between the port core and its SCK rate generator
`timescale 1ns/1ps
interface smsbp_clk_if;
	logic       run;
	logic [2:0] rate;
	logic       tick;
	modport gen  (input run, input rate, output tick);
	modport user (output run, output rate, input tick);
endinterface : smsbp_clk_if

// >>> rtl/smsbp_clkgen.sv
// Master SCK half-period tick generator
`timescale 1ns/1ps
module smsbp_clkgen
	import smsbp_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	smsbp_clk_if.gen  cg
);
	logic [6:0] cnt_r;
	logic [6:0] half;

	assign half    = smsbp_half(cg.rate); // R17
	assign cg.tick = cg.run && (cnt_r == half - HALF_ONE);

	// Restarts on every run so the first edge comes a full half period after the load
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_r <= 7'h00;
		else if (!cg.run || cg.tick)
			cnt_r <= 7'h00;
		else
			cnt_r <= cnt_r + HALF_ONE;
	end
endmodule // smsbp_clkgen

// >>> rtl/smsbp_top.sv
// Byte-wide SPI port, master or slave, with flags and pin overrides
// Overview of operation
// R1: Master data write starts the clock generator
// R2: Master stops after byte, sets done flag
// R3: Done flag with enable raises interrupt request
// R4: Master never drives select by itself
// R5: Master side frames each packet with select
// R6: MOSI master-to-slave, MISO slave-to-master, simultaneously exchanged
// R7: Idle slave keeps MISO released
// R8: Slave byte waits for select low
// R9: Slave sets flag after full byte
// R10: Received byte kept in receive buffer
// R11: No new transmit byte during shift
// R12: Unread received byte overwritten by next
// R13: Slave SCK at most quarter clock rate
// R14: Enabled port overrides pin directions
// R15: LSB-first or MSB-first selectable
// R16: Full duplex, master or slave selectable
// R17: Seven bit rates including half clock
// R18: Interrupt works while processor idles
// R19: Select high resets slave shift logic
// R20: Select low as master forces slave mode; code does so only while SS is an input (user_dir[PIN_SS] low)
// R21: Polarity sets idle level, phase sets sampling
// R22: Data write mid-transfer sets collision flag
// R23: Done flag clears by service or status-data
// R24: All control and status reset to zero
`timescale 1ns/1ps
module smsbp_top
	import smsbp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ctrl_wr,
	input  wire logic       sts_wr,
	input  wire logic       data_wr,
	input  wire logic [7:0] wdata,
	input  wire logic       sts_rd,
	input  wire logic       data_rd,
	input  wire logic       irq_ack,
	output logic      [7:0] ctrl_q,
	output logic      [7:0] sts_q,
	output logic      [7:0] rdata,
	output logic            irq,
	input  wire logic [3:0] user_dir,
	input  wire logic [3:0] gpio_out,
	input  wire logic [3:0] pin_i,
	output logic      [3:0] pin_o,
	output logic      [3:0] pin_oe
);
	logic [7:0]  port_control_reg_r;
	logic        double_rate_bit_r;
	logic        xfer_done_flag_r;
	logic        write_collision_flag_r;
	logic        clr_arm_r;
	logic        write_collision_flag_arm_r;
	logic [7:0]  shift_data_reg_r;
	logic [7:0]  rx_buf_r;
	logic        samp_r;
	logic [3:0]  cnt_r;
	logic [3:0]  edge_r;
	logic        sck_r;
	logic        sck_d_r;
	smsbp_mst_e  mst_r;
	logic [3:0]  s1_r;
	logic [3:0]  s2_r;

	logic en, master_select, lsb, cpol, cpha;
	logic s_act, s_edge, lead, ev, samp_ev, shft_ev, fin, in_bit, out_bit;
	logic start, busy, mode_fault, data_acc;
	logic [7:0] rx_nxt;

	smsbp_clk_if cgi ();

	smsbp_clkgen u_clkgen (
		.clk   (clk),
		.rst_n (rst_n),
		.cg    (cgi.gen)
	);

	assign en            = port_control_reg_r[CB_EN];
	assign master_select = port_control_reg_r[CB_MST]; // R16
	assign lsb           = port_control_reg_r[CB_LSB]; // R15
	assign cpol          = port_control_reg_r[CB_CPOL];
	assign cpha          = port_control_reg_r[CB_CPHA];

	// Pins come from another domain; only the second stage is read
	genvar gi;
	generate
		for (gi = 0; gi < PIN_NUM; gi++) begin : g_sync
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_r[gi] <= 1'b1;
					s2_r[gi] <= 1'b1;
				end else begin
					s1_r[gi] <= pin_i[gi];
					s2_r[gi] <= s1_r[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sck_d_r <= 1'b1;
		else
			sck_d_r <= s2_r[PIN_SCK];
	end

	// Slave sees SCK only through the synchroniser, hence the quarter-rate ceiling
	assign s_act  = en && !master_select && !s2_r[PIN_SS]; // R8 R13
	assign s_edge = s2_r[PIN_SCK] != sck_d_r;

	assign cgi.run  = (mst_r == MS_RUN);
	assign cgi.rate = {double_rate_bit_r, port_control_reg_r[CB_RATE_HI], port_control_reg_r[CB_RATE_LO]}; // R17

	// Leading edge leaves the idle level set by polarity
	assign lead    = master_select ? !edge_r[0] : (sck_d_r == cpol); // R21
	assign ev      = master_select ? (cgi.run && cgi.tick) : (s_act && s_edge);
	assign samp_ev = ev && (lead ^ cpha); // R21
	assign shft_ev = ev && !(lead ^ cpha) && (cnt_r != CNT_ZERO);
	assign in_bit  = master_select ? s2_r[PIN_MISO] : s2_r[PIN_MOSI]; // R6
	assign out_bit = lsb ? shift_data_reg_r[0] : shift_data_reg_r[7];
	assign fin     = (cpha && samp_ev && cnt_r == CNT_LAST) || (!cpha && shft_ev && cnt_r == CNT_FULL);
	assign rx_nxt  = cpha ? smsbp_shin(shift_data_reg_r, in_bit, lsb) : smsbp_shin(shift_data_reg_r, samp_r, lsb);

	assign busy       = master_select ? (mst_r == MS_RUN) : (s_act && cnt_r != CNT_ZERO);
	assign start      = en && master_select && data_wr && (mst_r == MS_IDLE); // R1
	assign mode_fault = en && master_select && !user_dir[PIN_SS] && !s2_r[PIN_SS]; // R20
	assign data_acc   = data_wr || data_rd;

	// Control byte; a mode fault drops master select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_control_reg_r <= CTRL_RST; // R24
			double_rate_bit_r  <= BIT_RST;
		end else begin
			if (ctrl_wr)
				port_control_reg_r <= wdata;
			else if (mode_fault)
				port_control_reg_r[CB_MST] <= 1'b0; // R20
			if (sts_wr)
				double_rate_bit_r <= wdata[SB_DBL];
		end
	end

	// Master sequencer, sixteen half periods per byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mst_r  <= MS_IDLE;
			edge_r <= CNT_ZERO;
			sck_r  <= 1'b0;
		end else begin
			case (mst_r)
				MS_IDLE: begin
					sck_r  <= cpol; // R21
					edge_r <= CNT_ZERO;
					if (start)
						mst_r <= MS_RUN; // R1
				end
				MS_RUN: begin
					if (mode_fault || !en || !master_select) begin
						mst_r <= MS_IDLE;
					end else if (cgi.tick) begin
						sck_r  <= !sck_r;
						edge_r <= edge_r + 4'h1;
						if (fin)
							mst_r <= MS_IDLE; // R2
					end
				end
				default: mst_r <= MS_IDLE;
			endcase
		end
	end

	// Shared shift register; both ends exchange bits on the same edges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_data_reg_r <= DATA_RST;
			samp_r           <= 1'b0;
			cnt_r            <= CNT_ZERO;
		end else begin
			if (!master_select && !s_act) begin
				cnt_r <= CNT_ZERO; // R19
			end else if (start || fin || mode_fault || (master_select && mst_r == MS_IDLE)) begin
				cnt_r <= CNT_ZERO;
			end else if (samp_ev) begin
				cnt_r <= cnt_r + 4'h1;
			end
			if (samp_ev)
				samp_r <= in_bit;
			// Writes during a transfer are refused so the byte in flight survives
			if (data_wr && !busy)
				shift_data_reg_r <= wdata; // R8 R11
			else if (fin)
				shift_data_reg_r <= rx_nxt; // R6
			else if (shft_ev)
				shift_data_reg_r <= smsbp_shin(shift_data_reg_r, samp_r, lsb); // R6
		end
	end

	// Receive buffer; an unread byte is simply overwritten
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rx_buf_r <= DATA_RST;
		else if (fin)
			rx_buf_r <= rx_nxt; // R10 R12
	end

	// Flags; a new event in the clearing cycle wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xfer_done_flag_r       <= 1'b0;
			write_collision_flag_r <= 1'b0;
			clr_arm_r              <= 1'b0;
			write_collision_flag_arm_r             <= 1'b0;
		end else begin
			if (sts_rd && xfer_done_flag_r)
				clr_arm_r <= 1'b1;
			else if (data_acc || irq_ack)
				clr_arm_r <= 1'b0;
			if (sts_rd && write_collision_flag_r)
				write_collision_flag_arm_r <= 1'b1;
			else if (data_acc)
				write_collision_flag_arm_r <= 1'b0;
			if (fin || mode_fault)
				xfer_done_flag_r <= 1'b1; // R2 R9 R20
			else if (irq_ack || (data_acc && (clr_arm_r || write_collision_flag_arm_r)))
				xfer_done_flag_r <= 1'b0; // R23
			if (data_wr && busy)
				write_collision_flag_r <= 1'b1; // R22
			else if (data_acc && write_collision_flag_arm_r)
				write_collision_flag_r <= 1'b0; // R22
		end
	end

	// Level request, so it reaches an idling processor without any clock gating
	assign irq    = xfer_done_flag_r && port_control_reg_r[CB_IRQ_EN]; // R3 R18
	assign ctrl_q = port_control_reg_r;
	assign sts_q  = {xfer_done_flag_r, write_collision_flag_r, 5'h00, double_rate_bit_r};
	assign rdata  = rx_buf_r;

	// Direction overrides; select output is always the software level
	always_comb begin
		pin_o  = gpio_out; // R4
		pin_oe = user_dir;
		if (en && master_select) begin
			pin_o[PIN_MOSI]  = out_bit;
			pin_o[PIN_SCK]   = sck_r;
			pin_oe[PIN_MISO] = 1'b0; // R14
		end else if (en) begin
			pin_o[PIN_MISO]  = out_bit;
			pin_oe[PIN_MOSI] = 1'b0; // R14
			pin_oe[PIN_SCK]  = 1'b0;
			pin_oe[PIN_SS]   = 1'b0;
			pin_oe[PIN_MISO] = user_dir[PIN_MISO] && !s2_r[PIN_SS]; // R7
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_start;
		start |=> mst_r == MS_RUN;
	endproperty
	a_start: assert property (p_start) else $error("master write did not start"); // R1

	property p_stop;
		(mst_r == MS_RUN) && fin |=> (mst_r == MS_IDLE) && xfer_done_flag_r;
	endproperty
	a_stop: assert property (p_stop) else $error("master did not stop with flag"); // R2

	property p_irq;
		fin && port_control_reg_r[CB_IRQ_EN] && !ctrl_wr |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("no interrupt request"); // R3

	property p_ss_sw;
		(mst_r == MS_RUN) |-> pin_o[PIN_SS] == gpio_out[PIN_SS] && pin_oe[PIN_SS] == user_dir[PIN_SS];
	endproperty
	a_ss_sw: assert property (p_ss_sw) else $error("select driven by port"); // R4

	property p_miso_off;
		en && !master_select && s2_r[PIN_SS] |-> !pin_oe[PIN_MISO];
	endproperty
	a_miso_off: assert property (p_miso_off) else $error("idle slave drives MISO"); // R7

	property p_ss_reset;
		en && !master_select && $rose(s2_r[PIN_SS]) |-> ##1 cnt_r == CNT_ZERO [*2];
	endproperty
	a_ss_reset: assert property (p_ss_reset) else $error("slave count not reset"); // R19

	property p_rxbuf;
		fin |=> rx_buf_r == $past(rx_nxt) && xfer_done_flag_r;
	endproperty
	a_rxbuf: assert property (p_rxbuf) else $error("receive buffer not loaded"); // R10

	property p_master_miso;
		en && master_select |-> !pin_oe[PIN_MISO];
	endproperty
	a_master_miso: assert property (p_master_miso) else $error("master drives MISO"); // R14

	property p_fault;
		mode_fault && !ctrl_wr |=> !master_select && xfer_done_flag_r;
	endproperty
	a_fault: assert property (p_fault) else $error("mode fault not handled"); // R20

	property p_write_collision_flag;
		data_wr && busy |=> write_collision_flag_r && ($stable(shift_data_reg_r) || $past(ev));
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged"); // R22

	c_master_byte: cover property (mst_r == MS_RUN && fin);
	c_slave_byte:  cover property (!master_select && fin);
	c_fault:       cover property (mode_fault);
	c_collision:   cover property (data_wr && busy);
endmodule // smsbp_top

// >>> testbench/smsbp_peer.sv
// Far-side SPI party: slave while the port masters, master while it is a slave
`timescale 1ns/1ps
module smsbp_peer (
	input	wire logic [3:0]	dut_o,
	input	wire logic [3:0]	dut_oe,
	input	wire logic		pm,
	input	wire logic [2:0]	mode,
	input	wire logic [7:0]	ptx,
	output	logic [3:0]		pin_w,
	output	logic [7:0]		rx_byte
);
	logic [3:0]	p_o;
	logic [3:0]	p_oe;
	logic [7:0]	tx_r = 8'h00;
	logic		hz_r = 1'b0;
	logic		sck_r = 1'b0;
	logic		ss_r = 1'b1;
	logic		dq_r = 1'b0;
	logic		tb;
	int		sft = 0;
	int		idx;
	// Released pins wander so a stale level never reads as data
	always #50 hz_r = ~hz_r;
	// Data as it stood half a clock before the edge; a same-step change is not taken
	always #100 dq_r = pm ? pin_w[1] : pin_w[0];
	assign pin_w = (dut_oe & dut_o) | (~dut_oe & p_oe & p_o) | (~dut_oe & ~p_oe & {4{hz_r}});
	always_comb begin
		idx = mode[0] ? ((sft > 0) ? sft - 1 : 0) : sft;
		if (idx > 7)
			idx = 7;
	end
	assign tb = tx_r[mode[2] ? idx : 7 - idx];
	assign p_o = {ss_r, sck_r, tb, tb};
	assign p_oe = pm ? 4'hD : {2'b00, ~pin_w[3], 1'b0};
	// New frame restarts the bit count
	always @(negedge pin_w[3]) begin
		tx_r = ptx;
		sft = 0;
	end
	always @(pin_w[2]) begin
		if (!pin_w[3]) begin
			if (pin_w[2] ^ mode[1] ^ mode[0])
				rx_byte = mode[2] ? {dq_r, rx_byte[7:1]} : {rx_byte[6:0], dq_r};
			else
				sft++;
		end
	end
	// 800 ns SCK, slower than a quarter of clk; idle SCK stands still
	task automatic xfer(input int nb);
		ss_r = 1'b0;
		#400;
		repeat (2 * nb) begin
			sck_r = ~sck_r;
			#400;
		end
		ss_r = 1'b1;
		#400;
	endtask
endmodule // smsbp_peer

// >>> testbench/smsbp_top_bench.sv
// Self-checking bench of the byte port against a far-side SPI peer
`timescale 1ns/1ps
module smsbp_top_bench
	import smsbp_pkg::*;
;
	logic		clk = 1'b0;
	logic		rst_n = 1'b0;
	logic [5:0]	stb = 6'h00;
	logic [7:0]	wdata = 8'h00;
	logic [3:0]	user_dir = 4'hF;
	logic [3:0]	gpio_out = 4'h8;
	logic		pm = 1'b0;
	logic [2:0]	mode = 3'h0;
	logic [7:0]	ptx = 8'h00;
	logic [7:0]	ctrl_q, sts_q, rdata, rx_byte;
	logic [3:0]	pin_w, pin_o, pin_oe;
	logic		irq;
	int		failures = 0;
	int		n_checks = 0;
	int		n;
	localparam int HT [8] = '{2, 8, 32, 64, 1, 4, 16, 32};
	localparam logic [7:0] CT [8] = '{8'h50, 8'h51, 8'h5E, 8'h77, 8'hD8, 8'h75, 8'h7A, 8'hDF};
	localparam logic [7:0] DT [8] = '{8'hA5, 8'h01, 8'h80, 8'hC3, 8'h5A, 8'hFE, 8'h7F, 8'h96};
	always #50 clk = ~clk;
	smsbp_top u_dut (.clk(clk), .rst_n(rst_n), .ctrl_wr(stb[0]), .sts_wr(stb[1]), .data_wr(stb[2]),
		.wdata(wdata), .sts_rd(stb[3]), .data_rd(stb[4]), .irq_ack(stb[5]), .ctrl_q(ctrl_q),
		.sts_q(sts_q), .rdata(rdata), .irq(irq), .user_dir(user_dir), .gpio_out(gpio_out),
		.pin_i(pin_w), .pin_o(pin_o), .pin_oe(pin_oe));
	smsbp_peer u_peer (.dut_o(pin_o), .dut_oe(pin_oe), .pm(pm), .mode(mode), .ptx(ptx),
		.pin_w(pin_w), .rx_byte(rx_byte));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic st(input int k, input logic [7:0] d);
		wdata = d;
		stb[k] = 1'b1;
		@(posedge clk);
		#1;
		stb = 6'h00;
		@(posedge clk);
		#1;
	endtask
	// Bounded wait; running out counts as a mismatch
	task automatic wait_done();
		n = 0;
		while (sts_q[SB_FLAG] !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 3000)
			failures++;
	endtask
	task automatic px(input logic [7:0] d, input int nb);
		ptx = d;
		u_peer.xfer(nb);
		@(posedge clk);
		#1;
	endtask
	task automatic chk_rst();
		chk(16'({irq, ctrl_q}), 16'h0000);
		chk({sts_q, rdata}, 16'h0000);
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#3000000;
		failures++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge clk);
		#1;
		chk_rst();
		rst_n = 1'b1;
		@(posedge clk);
		#1;
		for (int i = 0; i < 8; i++) begin
			mode = {CT[i][5], CT[i][3], CT[i][2]};
			ptx = {DT[i][3:0], DT[i][7:4]};
			st(1, 8'(i / 4));
			st(0, CT[i]);
			chk(16'(sts_q), 16'(i / 4));
			gpio_out = 4'h0;
			st(2, DT[i]);
			wait_done();
			chk(16'(n), 16'(16 * HT[i] - 1));
			chk(16'(rx_byte), 16'(DT[i]));
			if (HT[i] > 3)
				chk(16'(rdata), 16'(ptx));
			chk(16'({pin_oe[1], pin_o[2], pin_oe[3], pin_o[3]}), 16'({CT[i][3], 2'b10}));
			gpio_out = 4'h8;
			if (CT[i][7]) begin
				chk(16'(irq), 16'h0001);
				st(5, 8'h00);
				chk(16'({irq, sts_q[SB_FLAG]}), 16'h0000);
			end else begin
				chk(16'(irq), 16'h0000);
				st(3, 8'h00);
				st(4, 8'h00);
				chk(16'(sts_q[SB_FLAG]), 16'h0000);
			end
		end
		// Second write lands mid-shift and must not disturb the byte
		mode = 3'h0;
		st(0, 8'h51);
		gpio_out = 4'h0;
		st(2, 8'h69);
		st(2, 8'h96);
		chk(16'(sts_q[7:6]), 16'h0001);
		wait_done();
		chk(16'(rx_byte), 16'h0069);
		st(3, 8'h00);
		st(4, 8'h00);
		chk(16'(sts_q[7:6]), 16'h0000);
		gpio_out = 4'h8;
		user_dir = 4'h7;
		pm = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		u_peer.ss_r = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		chk(16'({ctrl_q[CB_MST], sts_q[SB_FLAG], pin_oe}), 16'h0012);
		u_peer.ss_r = 1'b1;
		user_dir = 4'hF;
		st(3, 8'h00);
		st(4, 8'h00);
		chk(16'(pin_oe), 16'h0000);
		st(2, 8'hA5);
		// Clock pulses with select high must leave the loaded byte alone
		repeat (4) begin
			u_peer.sck_r = ~u_peer.sck_r;
			#400;
		end
		px(8'h3C, 8);
		chk(16'({sts_q[SB_FLAG], rx_byte}), 16'h01A5);
		chk(16'(rdata), 16'h003C);
		px(8'h22, 8);
		px(8'h33, 8);
		chk(16'(rdata), 16'h0033);
		st(3, 8'h00);
		st(4, 8'h00);
		px(8'hC7, 4);
		chk(16'(sts_q[SB_FLAG]), 16'h0000);
		px(8'h5A, 8);
		chk(16'({sts_q[SB_FLAG], rdata}), 16'h015A);
		rst_n = 1'b0;
		@(posedge clk);
		#1;
		chk_rst();
		rst_n = 1'b1;
		wrap_up();
	end
endmodule // smsbp_top_bench
